// ==== bench/bitstream_source.sv ====
// Purpose: Bus master standing in for the bitstream source.
// Assumes: Classic single cycles, ack sampled on clk_i.
// Notes: Released data shows the inverse of the last word.
`timescale 1ns/1ps
`default_nettype none
module bitstream_source (
    input wire logic clk_i,
    input wire logic ack_i,
    output var logic cyc_o = 1'b0,
    output var logic stb_o = 1'b0,
    output var logic we_o = 1'b0,
    output var logic [3:0] adr_o = 4'h0,
    output var logic [31:0] dat_o = 32'h0
);
    int n_late = 0;
    task xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= w;
        adr_o <= a;
        dat_o <= d;
        i = 0;
        do
        begin
            @(posedge clk_i);
            i++;
        end
        while (!ack_i && i < 16);
        if (!ack_i)
            n_late++;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        we_o <= 1'b0;
        dat_o <= ~d;
    endtask
endmodule
`default_nettype wire

// ==== bench/config_options_startup_asserts.sv ====
// Purpose: Port checks for the options and startup block.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound from the bench; watches design inputs and outputs.
`timescale 1ns/1ps
`default_nettype none
module config_options_startup_asserts (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic done_pin_o,
    input wire logic done_pin_oe_n_o,
    input wire logic capture_request_i,
    input wire logic capture_load_o,
    input wire logic crc_check_enable_o,
    input wire logic clock_manager_reset_o,
    input wire logic global_io_tristate_o,
    input wire logic global_write_enable_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic take;
    assign take = cyc_i & stb_i & ~ack_o;

    ack_resp_a:
    assert property (take |=> ack_o)
        else $error("request not answered next cycle");
    ack_pulse_a:
    assert property (ack_o |=> !ack_o)
        else $error("ack held past one cycle");
    crc_follow_a:
    assert property (take && we_i && adr_i == 4'h0 && sel_i[3]
        |=> ##1 crc_check_enable_o == !$past(dat_i[29], 2))
        else $error("crc enable not following bypass bit");
    reserved_zero_a:
    assert property (take && !we_i && adr_i == 4'h0
        |=> dat_o[31:30] == 2'h0 && dat_o[28:27] == 2'h0)
        else $error("reserved option bits read nonzero");
    done_low_a:
    assert property (!done_pin_o |-> !done_pin_oe_n_o)
        else $error("done pin not driven low before release");
    done_float_a:
    assert property (done_pin_oe_n_o |-> done_pin_o)
        else $error("done pin floated while not released");
    reset_state_a:
    assert property ($past(rst_i) |-> global_io_tristate_o
        && !global_write_enable_o && !done_pin_o)
        else $error("startup outputs wrong after reset");
    mgr_pulse_a:
    assert property ($rose(clock_manager_reset_o)
        |=> clock_manager_reset_o [*8])
        else $error("manager reset pulse too short");
    capture_cause_a:
    assert property (capture_load_o |-> $past(capture_request_i))
        else $error("capture load without request");
endmodule
`default_nettype wire

// ==== bench/config_options_startup_control_bench.sv ====
// Purpose: Self-checking bench for options and startup.
// Assumes: Startup clocks are slow pins sampled by the block.
// Notes: Read data are matched from a queue of expectations.
`timescale 1ns/1ps
`default_nettype none
module config_options_startup_control_bench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic mm = 1'b0, cfg_clk = 1'b0, usr_clk = 1'b0;
    logic ext_low = 1'b0, cap_req = 1'b0;
    logic [7:0] b_match = 8'hFF, b_used = 8'hFF;
    logic [3:0] m_lock = 4'hF, m_used = 4'hF;
    logic [63:0] q[$];
    logic [63:0] e;
    logic [31:0] r;
    int err_total = 0, n_checks = 0, cap_n = 0, mgr_n = 0;
    int lag0, lag1;
    int seed = 32'h8AF7;
    wire logic cyc, stb, we, ack, ck_o, ck_oe, done_o, done_oe, pin;
    wire logic cap_o, crc_o, mrst_o, gts_o, gwe_o, sense_o;
    wire logic [3:0] adr;
    wire logic [31:0] wdat, rdat;
    // Pull-up on the pin; the bench may hold it low
    assign pin = ext_low ? 1'b0 : (done_oe ? 1'b1 : done_o);

    bitstream_source i_bitstream_source (.clk_i(clk_i), .ack_i(ack),
        .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .dat_o(wdat));
    config_options_startup i_config_options_startup (.clk_i(clk_i),
        .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(4'hF), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
        .master_mode_i(mm), .config_clock_i(cfg_clk),
        .user_clock_i(usr_clk), .config_clock_o(ck_o),
        .config_clock_oe_n_o(ck_oe), .done_pin_i(pin),
        .done_pin_o(done_o), .done_pin_oe_n_o(done_oe),
        .bank_match_i(b_match), .bank_used_i(b_used),
        .mgr_locked_i(m_lock), .mgr_used_i(m_used),
        .capture_request_i(cap_req), .capture_load_o(cap_o),
        .crc_check_enable_o(crc_o), .clock_manager_reset_o(mrst_o),
        .global_io_tristate_o(gts_o), .global_write_enable_o(gwe_o),
        .done_pin_sense_o(sense_o));

    always #5 clk_i = ~clk_i;

    task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        n_checks++;
        if (g !== x)
        begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, x, g);
        end
    endtask

    task print_verdict;
        err_total += i_bitstream_source.n_late;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Read results are matched oldest first against the notes
    always @(posedge clk_i)
    begin
        cap_n <= cap_n + cap_o;
        mgr_n <= mgr_n + mrst_o;
        if (ack && !we && q.size() > 0)
        begin
            e = q.pop_front();
            chk("read data", e[31:0], rdat & e[63:32]);
        end
    end

    task xq(input logic w, input logic [3:0] a, input logic [31:0] d);
        i_bitstream_source.xfer(w, a, d);
        if (i_bitstream_source.n_late != 0)
            print_verdict();
    endtask

    task rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] x);
        q.push_back({m, x & m});
        xq(1'b0, a, 32'h0);
    endtask

    task do_reset;
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask

    // Long levels so the three-stage sampler sees every edge
    task pulse(input logic usr);
        @(posedge clk_i);
        usr_clk <= usr;
        cfg_clk <= !usr;
        repeat (8) @(posedge clk_i);
        usr_clk <= 1'b0;
        cfg_clk <= 1'b0;
        repeat (8) @(posedge clk_i);
    endtask

    task count(input logic [31:0] opt, input logic [31:0] cmd,
        input logic c, input int x);
        int n0, n1;
        xq(1'b1, 4'h0, opt);
        n0 = cap_n;
        n1 = mgr_n;
        if (cmd != 0)
            xq(1'b1, 4'h8, cmd);
        cap_req <= c;
        repeat (5) @(posedge clk_i);
        cap_req <= 1'b0;
        repeat (15) @(posedge clk_i);
        chk("pulse cycles", x, cap_n - n0 + mgr_n - n1);
    endtask

    task freq(input logic [5:0] c, input int half);
        int n;
        xq(1'b1, 4'h0, {9'h0, c, 17'h0FC0});
        repeat (40) @(posedge clk_i);
        for (int j = 0; j < 2; j++)
        begin
            r[0] = ck_o;
            n = 0;
            while (ck_o === r[0] && n < 40)
            begin
                @(posedge clk_i);
                n++;
            end
        end
        chk("half period", half, n);
        chk("clock drive", 0, ck_oe);
    endtask

    task run(input logic [31:0] opt, input logic usr, input int lift);
        int s;
        logic rel;
        s = 0;
        do_reset();
        m_lock <= {4{lift == 0}};
        m_used <= 4'hF;
        b_used <= 8'hFF;
        b_match <= {8{lift == 0}};
        xq(1'b1, 4'h0, opt);
        xq(1'b1, 4'h8, 32'h1);
        for (int k = 1; k <= 9; k++)
        begin
            pulse(usr);
            if (s < 7 && !(k <= lift && ((s == opt[11:9] && opt[11:9] != 3'h7)
                || (s == opt[8:6] && opt[8:6] != 3'h7))))
                s++;
            rel = s > opt[14:12];
            r = {22'h0, s[2:0], 1'b1, rel, s > opt[2:0], s <= opt[5:3],
                k > lift, k > lift, rel};
            rd(4'h4, 32'h3FF, r);
            chk("done pin", {rel, rel & !opt[24]}, {done_o, done_oe});
            chk("globals", {s <= opt[5:3], s > opt[2:0]}, {gts_o, gwe_o});
            b_match <= {8{k >= lift}};
            m_lock <= {4{k >= lift}};
        end
    endtask

    // Edges from forcing the pin low until the sense output follows
    task lag(input logic [31:0] opt, output int n);
        xq(1'b1, 4'h0, opt);
        ext_low <= 1'b1;
        n = 0;
        while (sense_o !== 1'b0 && n < 40)
        begin
            @(posedge clk_i);
            n++;
        end
        ext_low <= 1'b0;
        repeat (12) @(posedge clk_i);
    endtask

    initial
    begin
        repeat (60000) @(posedge clk_i);
        err_total++;
        print_verdict();
    end

    initial
    begin
        do_reset();
        rd(4'h0, 32'hFFFFFFFF, 32'h00000FC0);
        repeat (4)
        begin
            r = $random(seed);
            xq(1'b1, 4'h0, r);
            rd(4'h0, 32'hFFFFFFFF, r & 32'h27FFFFFF);
            chk("crc enable", !r[29], crc_o);
        end
        rd(4'hC, 32'hFFFFFFFF, 32'h0);
        repeat (4)
        begin
            {b_used, b_match} <= $random(seed);
            {m_used, m_lock} <= $random(seed);
            repeat (8) @(posedge clk_i);
            r = {m_lock | ~m_used, b_match | ~b_used};
            rd(4'h4, 32'h6, {&r[11:8], &r[7:0], 1'b0});
        end
        count(32'h00000FC0, 0, 1'b1, 5);
        count(32'h00800FC0, 0, 1'b1, 1);
        count(32'h04000FC0, 32'h2, 1'b0, 10);
        count(32'h00000FC0, 32'h2, 1'b0, 0);
        mm <= 1'b1;
        freq(6'h02, 12);
        freq(6'h2D, 1);
        mm <= 1'b0;
        run(32'h000097E5, 1'b1, 5);
        ext_low <= 1'b1;
        repeat (12) @(posedge clk_i);
        chk("done sense", 0, sense_o);
        ext_low <= 1'b0;
        run(32'h01005E82, 1'b0, 3);
        lag(32'h01005E82, lag0);
        lag(32'h03005E82, lag1);
        chk("pipe stage", lag0 + 1, lag1);
        print_verdict();
    end
endmodule

bind config_options_startup config_options_startup_asserts
    i_config_options_startup_asserts (.clk_i, .rst_i, .cyc_i, .stb_i,
    .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .done_pin_o,
    .done_pin_oe_n_o, .capture_request_i, .capture_load_o,
    .crc_check_enable_o, .clock_manager_reset_o, .global_io_tristate_o,
    .global_write_enable_o);
`default_nettype wire

// ==== logic/config_options_startup.v ====
// Purpose: Configuration options register and startup sequencer.
// Assumes: Classic Wishbone slave, one clock clk_i at 100 MHz.
// Notes:   Startup steps advance on edges of a sampled slow clock.
`timescale 1ns/1ps
`default_nettype none
`include "config_opts_map.vh"

module config_options_startup
#(
    parameter BANKS = 8,
    parameter MGRS = 4
)
(
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [3:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    input wire master_mode_i,
    input wire config_clock_i,
    input wire user_clock_i,
    output wire config_clock_o,
    output wire config_clock_oe_n_o,
    input wire done_pin_i,
    output wire done_pin_o,
    output wire done_pin_oe_n_o,
    input wire [BANKS-1:0] bank_match_i,
    input wire [BANKS-1:0] bank_used_i,
    input wire [MGRS-1:0] mgr_locked_i,
    input wire [MGRS-1:0] mgr_used_i,
    input wire capture_request_i,
    output reg capture_load_o,
    output reg crc_check_enable_o,
    output reg clock_manager_reset_o,
    output reg global_io_tristate_o,
    output reg global_write_enable_o,
    output reg done_pin_sense_o
);

// ----------------------------------------------------------------------
// Functions
// ----------------------------------------------------------------------
// Half period of the generated clock, in clk_i cycles, rounded down.
// Unlisted codes fall back to the slowest rate, the safe choice.
function [3:0] half_period;
    input [5:0] code;
    begin
        case (code)
            6'h02: half_period = 4'hC;
            6'h11: half_period = 4'hA;
            6'h04: half_period = 4'h7;
            6'h05: half_period = 4'h6;
            6'h06: half_period = 4'h5;
            6'h07: half_period = 4'h5;
            6'h0A: half_period = 4'h3;
            6'h0D: half_period = 4'h3;
            6'h17: half_period = 4'h2;
            6'h1A: half_period = 4'h1;
            6'h1D: half_period = 4'h1;
            6'h32: half_period = 4'h1;
            6'h27: half_period = 4'h1;
            6'h33: half_period = 4'h1;
            6'h2A: half_period = 4'h1;
            6'h34: half_period = 4'h1;
            6'h2D: half_period = 4'h1;
            default: half_period = 4'hC;
        endcase
    end
endfunction

// Release codes 000..101 mean step 1..6; reached when step exceeds code
function reached;
    input [2:0] step;
    input [2:0] code;
    begin
        reached = (step > code);
    end
endfunction

// ----------------------------------------------------------------------
// Pin sampling
// ----------------------------------------------------------------------
localparam SW = 4 + BANKS + MGRS;

wire [SW-1:0] sync_w;
wire mode_s;
wire cfg_pin_s;
wire usr_s;
wire done_s;
wire [BANKS-1:0] match_s;
wire [MGRS-1:0] lock_s;

pin_sync3 #(.W(SW)) u_sync
(
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({mgr_locked_i, bank_match_i, done_pin_i, user_clock_i,
              config_clock_i, master_mode_i}),
    .sync_o(sync_w)
);

assign mode_s = sync_w[0];
assign cfg_pin_s = sync_w[1];
assign usr_s = sync_w[2];
assign done_s = sync_w[3];
assign match_s = sync_w[4+BANKS-1:4];
assign lock_s = sync_w[SW-1:4+BANKS];

// ----------------------------------------------------------------------
// Registers
// ----------------------------------------------------------------------
reg [31:0] opt_q;
reg [2:0] step_q;
reg running_q;
reg done_rel_q;
reg done_pipe_q;
reg cap_prev_q;
reg [3:0] div_cnt_q;
reg gen_clk_q;
reg sclk_prev_q;
reg [7:0] rst_cnt_q;

wire wb_req;
wire wb_wr;
wire [31:0] byte_mask;
wire [31:0] opt_d;
wire start_cmd;
wire high_cmd;
wire match_all;
wire lock_all;
wire cfg_clk;
reg sclk;
wire sclk_edge;
wire stall;

assign wb_req = cyc_i & stb_i & ~ack_o;
assign wb_wr = wb_req & we_i;
assign byte_mask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}},
                    {8{sel_i[0]}}};
assign opt_d = (opt_q & ~(byte_mask & `OPT_WRITABLE_MASK))
             | (dat_i & byte_mask & `OPT_WRITABLE_MASK);
assign start_cmd = wb_wr & (adr_i == `OFS_COMMAND) & sel_i[0]
                 & dat_i[`CMD_START];
assign high_cmd = wb_wr & (adr_i == `OFS_COMMAND) & sel_i[0]
                & dat_i[`CMD_GLOBAL_HIGH];

// ----------------------------------------------------------------------
// Wishbone slave, one wait state, unmapped reads give zero
// ----------------------------------------------------------------------
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        ack_o <= 1'b0;
        dat_o <= 32'h00000000;
        opt_q <= `OPT_RESET;
    end
    else
    begin
        ack_o <= wb_req;
        if (wb_wr && adr_i == `OFS_OPTION)
            opt_q <= opt_d;
        if (wb_req && !we_i)
        begin
            case (adr_i)
                `OFS_OPTION: dat_o <= opt_q;
                `OFS_STATUS: dat_o <= {22'h000000, step_q, running_q,
                                       done_rel_q, global_write_enable_o,
                                       global_io_tristate_o, lock_all,
                                       match_all, done_pin_sense_o};
                default: dat_o <= 32'h00000000;
            endcase
        end
    end
end

// ----------------------------------------------------------------------
// Master configuration clock generator
// ----------------------------------------------------------------------
// rate from frequency field
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        div_cnt_q <= 4'h0;
        gen_clk_q <= 1'b0;
    end
    else if (div_cnt_q + 4'h1 >= half_period(
             opt_q[`OPT_FREQ_HI:`OPT_FREQ_LO]))
    begin
        div_cnt_q <= 4'h0;
        gen_clk_q <= ~gen_clk_q;
    end
    else
    begin
        div_cnt_q <= div_cnt_q + 4'h1;
    end
end

// Only master mode drives the pin; otherwise it is an input
assign config_clock_o = gen_clk_q;
assign config_clock_oe_n_o = ~mode_s;
assign cfg_clk = mode_s ? gen_clk_q : cfg_pin_s;

// ----------------------------------------------------------------------
// Startup clock choice and wait conditions
// ----------------------------------------------------------------------
// sequencer clock source
always @*
begin
    case (opt_q[`OPT_SCLK_HI:`OPT_SCLK_LO])
        `SCLK_USER: sclk = usr_s;
        default: sclk = cfg_clk;
    endcase
end

assign sclk_edge = sclk & ~sclk_prev_q;

assign match_all = &(match_s | ~bank_used_i);
assign lock_all = &(lock_s | ~mgr_used_i);

assign stall = ((opt_q[`OPT_MATCH_HI:`OPT_MATCH_LO] != `WAIT_NEVER)
                && (opt_q[`OPT_MATCH_HI:`OPT_MATCH_LO] == step_q)
                && !match_all)
             || ((opt_q[`OPT_LOCK_HI:`OPT_LOCK_LO] != `WAIT_NEVER)
                && (opt_q[`OPT_LOCK_HI:`OPT_LOCK_LO] == step_q)
                && !lock_all);

// ----------------------------------------------------------------------
// Startup sequencer
// ----------------------------------------------------------------------
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        sclk_prev_q <= 1'b0;
        step_q <= 3'h0;
        running_q <= 1'b0;
    end
    else
    begin
        sclk_prev_q <= sclk;
        if (start_cmd)
        begin
            step_q <= 3'h0;
            running_q <= 1'b1;
        end
        // one step per rising edge unless stalled or already at STEP_LAST
        else if (running_q && sclk_edge && !stall
                 && step_q != `STEP_LAST)
        begin
            step_q <= step_q + 3'h1;
        end
    end
end

// ----------------------------------------------------------------------
// Global controls
// ----------------------------------------------------------------------
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        done_rel_q <= 1'b0;
        global_io_tristate_o <= 1'b1;
        global_write_enable_o <= 1'b0;
        crc_check_enable_o <= 1'b1;
    end
    else
    begin
        // DONE held low until its step
        done_rel_q <= running_q
                    && reached(step_q, opt_q[`OPT_DONE_HI:`OPT_DONE_LO]);
        global_io_tristate_o <= !(running_q
                    && reached(step_q, opt_q[`OPT_GTS_HI:`OPT_GTS_LO]));
        global_write_enable_o <= running_q
                    && reached(step_q, opt_q[`OPT_GWE_HI:`OPT_GWE_LO]);
        crc_check_enable_o <= !opt_q[`OPT_CRC_BYPASS];
    end
end

// released pin floats or drives high
assign done_pin_o = done_rel_q;
assign done_pin_oe_n_o = done_rel_q & ~opt_q[`OPT_DONE_DRIVE];

// ----------------------------------------------------------------------
// Done sense, capture and manager reset
// ----------------------------------------------------------------------
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        done_pipe_q <= 1'b0;
        done_pin_sense_o <= 1'b0;
        cap_prev_q <= 1'b0;
        capture_load_o <= 1'b0;
        rst_cnt_q <= 8'h00;
        clock_manager_reset_o <= 1'b0;
    end
    else
    begin
        // sampled pin level, never the release flag
        done_pipe_q <= done_s;
        done_pin_sense_o <= opt_q[`OPT_DONE_PIPE] ? done_pipe_q : done_s;
        cap_prev_q <= capture_request_i;
        capture_load_o <= capture_request_i
                        & (~opt_q[`OPT_ONE_SHOT] | ~cap_prev_q);
        // manager reset on global-high command
        // Pulse is stretched so slow managers see it
        if (high_cmd && opt_q[`OPT_SHUT_RST])
            rst_cnt_q <= `MGR_RESET_CYC;
        else if (rst_cnt_q != 8'h00)
            rst_cnt_q <= rst_cnt_q - 8'h01;
        clock_manager_reset_o <= (high_cmd && opt_q[`OPT_SHUT_RST])
                               || (rst_cnt_q > 8'h01);
    end
end

endmodule

`default_nettype wire

// ==== logic/config_opts_map.vh ====
// Purpose: Register offsets, field positions, reset values and timing
//          constants for the configuration options and startup block.
// Assumes: 32-bit classic Wishbone, word-aligned byte addresses.
// Notes:   Definitions only.
`ifndef CONFIG_OPTS_MAP_VH
`define CONFIG_OPTS_MAP_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_OPTION 4'h0
`define OFS_STATUS 4'h4
`define OFS_COMMAND 4'h8

// ----------------------------------------------------------------------
// Option register fields
// ----------------------------------------------------------------------
`define OPT_CRC_BYPASS 29
`define OPT_SHUT_RST 26
`define OPT_DONE_PIPE 25
`define OPT_DONE_DRIVE 24
`define OPT_ONE_SHOT 23
`define OPT_FREQ_HI 22
`define OPT_FREQ_LO 17
`define OPT_SCLK_HI 16
`define OPT_SCLK_LO 15
`define OPT_DONE_HI 14
`define OPT_DONE_LO 12
`define OPT_MATCH_HI 11
`define OPT_MATCH_LO 9
`define OPT_LOCK_HI 8
`define OPT_LOCK_LO 6
`define OPT_GTS_HI 5
`define OPT_GTS_LO 3
`define OPT_GWE_HI 2
`define OPT_GWE_LO 0
`define OPT_WRITABLE_MASK 32'h27FFFFFF
`define OPT_RESET 32'h00000FC0

// ----------------------------------------------------------------------
// Field codes
// ----------------------------------------------------------------------
`define SCLK_CONFIG 2'h0
`define SCLK_USER 2'h1
`define WAIT_NEVER 3'h7
`define STEP_LAST 3'h7

// ----------------------------------------------------------------------
// Command register bits (write one to trigger)
// ----------------------------------------------------------------------
`define CMD_START 0
`define CMD_GLOBAL_HIGH 1

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_MHZ 100
`define MGR_RESET_NS 100
// 100 ns at 100 MHz, sized to the stretch counter
`define MGR_RESET_CYC 8'h0A

`endif

// ==== logic/pin_sync3.v ====
// Purpose: Three-stage pin synchroniser with agreement filter.
// Assumes: Inputs are asynchronous to clk_i.
// Notes:   Output moves only when stages two and three agree.
`timescale 1ns/1ps
`default_nettype none

module pin_sync3
#(
    parameter W = 1
)
(
    input wire clk_i,
    input wire rst_i,
    input wire [W-1:0] async_i,
    output wire [W-1:0] sync_o
);

reg [W-1:0] s1_q;
reg [W-1:0] s2_q;
reg [W-1:0] s3_q;
reg [W-1:0] out_q;
integer i;

always @(posedge clk_i)
begin
    if (rst_i)
    begin
        s1_q <= {W{1'b0}};
        s2_q <= {W{1'b0}};
        s3_q <= {W{1'b0}};
        out_q <= {W{1'b0}};
    end
    else
    begin
        s1_q <= async_i;
        s2_q <= s1_q;
        s3_q <= s2_q;
        for (i = 0; i < W; i = i + 1)
        begin
            // Short glitches that only reach one stage are ignored
            if (s2_q[i] == s3_q[i])
                out_q[i] <= s3_q[i];
        end
    end
end

assign sync_o = out_q;

endmodule

`default_nettype wire
